// *** hw/ffm_pkg.sv ***
// package for the fault flag and event mask register block
// assumes an internal register port fed by the device's serial slave
package ffm_pkg;

	// register offsets
	localparam logic [7:0] FLT_FLAG_OFS = 8'h27;
	localparam logic [7:0] MASK_FIRST_OFS = 8'h28;
	localparam logic [7:0] MASK_SECOND_OFS = 8'h29;
	localparam logic [7:0] MASK_THIRD_OFS = 8'h2A;

	// reset values
	localparam logic [7:0] FLT_FLAG_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;

	// fault flag field positions
	localparam int SYS_SHORT_BIT = 7;
	localparam int SYS_OV_BIT = 6;
	localparam int RB_OV_BIT = 5;
	localparam int RB_UV_BIT = 4;
	localparam int TSHUT_BIT = 2;

	// first mask field positions
	localparam int IIN_LIM_BIT = 7;
	localparam int VIN_LIM_BIT = 6;
	localparam int WDOG_BIT = 5;
	localparam int WEAK_SRC_BIT = 4;
	localparam int PGOOD_BIT = 3;
	localparam int IN2_PRES_BIT = 2;
	localparam int IN1_PRES_BIT = 1;
	localparam int BUS_PRES_BIT = 0;

	// second mask field positions
	localparam int CHG_STAT_BIT = 7;
	localparam int ICO_BIT = 6;
	localparam int BUS_STAT_BIT = 4;
	localparam int DIE_THERMAL_REGULATION_BIT = 2;
	localparam int BAT_PRES_BIT = 1;
	localparam int PORT_DET_BIT = 0;

	// used flag bits and writable mask bits; reserved bits read zero
	localparam logic [7:0] FLT_FLAG_USED = 8'hF4;
	localparam logic [7:0] MASK_FIRST_WMASK = 8'hFF;
	localparam logic [7:0] MASK_SECOND_WMASK = 8'hD7;
	localparam logic [7:0] MASK_THIRD_WMASK = 8'h7F;

	// interrupt pulse timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int INT_PULSE_NS = 250;
	localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [3:0] INT_PULSE_LAST = 4'(INT_PULSE_CYC - 1);

	// analog conditions, all levels from the detection circuits
	typedef struct packed {
		logic sys_short;
		logic sys_ov;
		logic rb_ov;
		logic rb_uv;
		logic tshut;
		logic iin_lim;
		logic rb_cur;
		logic vin_lim;
		logic rb_volt;
		logic wdog_exp;
		logic weak_src;
		logic pgood;
		logic in2_pres;
		logic in1_pres;
		logic bus_pres;
		logic [2:0] chg_stat;
		logic [1:0] ico_stat;
		logic [3:0] bus_stat;
		logic die_thermal_regulation;
		logic bat_pres;
		logic port_det;
	} ffm_cond_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffm_req_t;

	typedef enum logic [1:0] {
		INT_IDLE = 2'b01,
		INT_PULSE = 2'b10
	} ffm_int_st_t;

endpackage

// *** hw/ffm_regs.sv ***
// fault flag register and event mask registers with interrupt pulse
// assumes register requests are one-cycle strobes, synchronous to clk
`timescale 1ns/1ns
`default_nettype none

module ffm_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// register port
	input wire ffm_pkg::ffm_req_t req,
	input wire logic reg_reset_cmd,
	output logic [7:0] rdata,
	// analog conditions
	input wire ffm_pkg::ffm_cond_t cond,
	// interrupt to host, active low
	output logic int_n
);

	function automatic logic rose(input logic now, input logic was);
		rose = now & ~was;
	endfunction

	function automatic logic is_write(input ffm_pkg::ffm_req_t r,
		input logic [7:0] ofs);
		is_write = r.wr & (r.addr == ofs);
	endfunction

	// condition history and fault flags
	ffm_pkg::ffm_cond_t cond_r;
	ffm_pkg::ffm_cond_t cond_nxt;
	logic primed_r;
	logic primed_nxt;
	logic [7:0] flt_r;
	logic [7:0] flt_nxt;
	logic [7:0] flt_set;

	always_comb
	begin
		flt_set = 8'h00;
		// no edges are seen until history holds a real sample
		if (primed_r)
		begin
			flt_set[ffm_pkg::SYS_SHORT_BIT] = rose(cond.sys_short,
				cond_r.sys_short);
			flt_set[ffm_pkg::SYS_OV_BIT] = rose(cond.sys_ov,
				cond_r.sys_ov);
			flt_set[ffm_pkg::RB_OV_BIT] = rose(cond.rb_ov,
				cond_r.rb_ov);
			flt_set[ffm_pkg::RB_UV_BIT] = rose(cond.rb_uv,
				cond_r.rb_uv);
			flt_set[ffm_pkg::TSHUT_BIT] = rose(cond.tshut,
				cond_r.tshut);
		end
		cond_nxt = cond;
		primed_nxt = 1'b1;
		flt_nxt = flt_r;
		// read clears; an event in the same cycle still sets
		if (req.rd && req.addr == ffm_pkg::FLT_FLAG_OFS)
		begin
			flt_nxt = 8'h00;
		end
		flt_nxt = (flt_nxt | flt_set) & ffm_pkg::FLT_FLAG_USED;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cond_r <= '0;
			primed_r <= 1'b0;
			flt_r <= ffm_pkg::FLT_FLAG_RST;
		end
		else if (clk_en)
		begin
			cond_r <= cond_nxt;
			primed_r <= primed_nxt;
			flt_r <= flt_nxt;
		end
	end

	// mask registers
	logic [7:0] mask0_r;
	logic [7:0] mask0_nxt;
	logic [7:0] mask1_r;
	logic [7:0] mask1_nxt;
	logic [7:0] mask2_r;
	logic [7:0] mask2_nxt;

	always_comb
	begin
		mask0_nxt = mask0_r;
		mask1_nxt = mask1_r;
		mask2_nxt = mask2_r;
		if (reg_reset_cmd)
		begin
			mask0_nxt = ffm_pkg::MASK_RST;
			mask1_nxt = ffm_pkg::MASK_RST;
			mask2_nxt = ffm_pkg::MASK_RST;
		end
		else
		begin
			if (is_write(req, ffm_pkg::MASK_FIRST_OFS))
			begin
				mask0_nxt = req.wdata & ffm_pkg::MASK_FIRST_WMASK;
			end
			if (is_write(req, ffm_pkg::MASK_SECOND_OFS))
			begin
				mask1_nxt = req.wdata & ffm_pkg::MASK_SECOND_WMASK;
			end
			if (is_write(req, ffm_pkg::MASK_THIRD_OFS))
			begin
				mask2_nxt = req.wdata & ffm_pkg::MASK_THIRD_WMASK;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mask0_r <= ffm_pkg::MASK_RST;
			mask1_r <= ffm_pkg::MASK_RST;
			mask2_r <= ffm_pkg::MASK_RST;
		end
		else if (clk_en)
		begin
			mask0_r <= mask0_nxt;
			mask1_r <= mask1_nxt;
			mask2_r <= mask2_nxt;
		end
	end

	// event detection gated by masks
	logic [7:0] ev0;
	logic [7:0] ev1;
	logic any_event;

	always_comb
	begin
		ev0 = 8'h00;
		ev1 = 8'h00;
		if (primed_r)
		begin
			ev0[ffm_pkg::IIN_LIM_BIT] = rose(cond.iin_lim, cond_r.iin_lim)
				| rose(cond.rb_cur, cond_r.rb_cur);
			ev0[ffm_pkg::VIN_LIM_BIT] = rose(cond.vin_lim, cond_r.vin_lim)
				| rose(cond.rb_volt, cond_r.rb_volt);
			ev0[ffm_pkg::WDOG_BIT] = rose(cond.wdog_exp,
				cond_r.wdog_exp);
			ev0[ffm_pkg::WEAK_SRC_BIT] = rose(cond.weak_src,
				cond_r.weak_src);
			ev0[ffm_pkg::PGOOD_BIT] = cond.pgood ^ cond_r.pgood;
			ev0[ffm_pkg::IN2_PRES_BIT] = cond.in2_pres
				^ cond_r.in2_pres;
			ev0[ffm_pkg::IN1_PRES_BIT] = cond.in1_pres
				^ cond_r.in1_pres;
			ev0[ffm_pkg::BUS_PRES_BIT] = cond.bus_pres
				^ cond_r.bus_pres;
			ev1[ffm_pkg::CHG_STAT_BIT] = cond.chg_stat
				!= cond_r.chg_stat;
			ev1[ffm_pkg::ICO_BIT] = cond.ico_stat
				!= cond_r.ico_stat;
			ev1[ffm_pkg::BUS_STAT_BIT] = cond.bus_stat
				!= cond_r.bus_stat;
			ev1[ffm_pkg::DIE_THERMAL_REGULATION_BIT] = rose(cond.die_thermal_regulation, cond_r.die_thermal_regulation);
			ev1[ffm_pkg::BAT_PRES_BIT] = cond.bat_pres
				^ cond_r.bat_pres;
			ev1[ffm_pkg::PORT_DET_BIT] = cond.port_det
				^ cond_r.port_det;
		end
		// a set mask bit suppresses its event
		any_event = |(ev0 & ~mask0_r) | |(ev1 & ~mask1_r);
	end

	// interrupt pulse; events during a pulse merge into it,
	// so the host must read status to learn every cause
	ffm_pkg::ffm_int_st_t st_r;
	ffm_pkg::ffm_int_st_t st_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			ffm_pkg::INT_IDLE:
			begin
				if (any_event)
				begin
					st_nxt = ffm_pkg::INT_PULSE;
					cnt_nxt = 4'h0;
				end
			end
			ffm_pkg::INT_PULSE:
			begin
				if (cnt_r == ffm_pkg::INT_PULSE_LAST)
				begin
					st_nxt = ffm_pkg::INT_IDLE;
				end
				else
				begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			default:
			begin
				st_nxt = ffm_pkg::INT_IDLE;
				cnt_nxt = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= ffm_pkg::INT_IDLE;
			cnt_r <= 4'h0;
		end
		else if (clk_en)
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// int_n comes straight from the state flop, no glitches
	assign int_n = ~st_r[1];

	// read data register
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = rdata_r;
		if (req.rd)
		begin
			unique case (req.addr)
				ffm_pkg::FLT_FLAG_OFS: rdata_nxt = flt_r;
				ffm_pkg::MASK_FIRST_OFS: rdata_nxt = mask0_r;
				ffm_pkg::MASK_SECOND_OFS: rdata_nxt = mask1_r;
				ffm_pkg::MASK_THIRD_OFS: rdata_nxt = mask2_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_r <= 8'h00;
		end
		else if (clk_en)
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

endmodule

`default_nettype wire

// *** verif/ffm_host_model.sv ***
// host side model: counts interrupt pulses seen on int_n
// assumes int_n is synchronous to clk and active low
`timescale 1ns/1ns
`default_nettype none
module ffm_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// interrupt in, count out
	input wire logic int_n,
	output logic [7:0] pulses
);
	logic q_r;
	// counts falling edges, so a merged pulse counts once
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q_r <= 1'b1;
			pulses <= 8'h00;
		end
		else
		begin
			q_r <= int_n;
			if (q_r && !int_n)
				pulses <= pulses + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** verif/ffm_regs_properties.sv ***
// checker for the flag and mask registers and the interrupt pulse
// shadows the first two masks and the flags from the ports, frozen by clk_en as in the design
`timescale 1ns/1ns
`default_nettype none
module ffm_regs_properties (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire ffm_pkg::ffm_req_t req,
	input wire logic reg_reset_cmd,
	input wire logic [7:0] rdata,
	input wire ffm_pkg::ffm_cond_t cond,
	input wire logic int_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic pr_r;
	logic [7:0] m0_r, m1_r, fl_r, ev0, ev1, fr;
	ffm_pkg::ffm_cond_t cq_r, r, t;
	wire rd27 = req.rd && req.addr == ffm_pkg::FLT_FLAG_OFS;
	assign r = cond & ~cq_r;
	assign t = cond ^ cq_r;
	// history is not primed at the first edge after reset
	assign ev0 = {r.iin_lim | r.rb_cur, r.vin_lim | r.rb_volt, r.wdog_exp,
		r.weak_src, t.pgood, t.in2_pres, t.in1_pres, t.bus_pres} & {8{pr_r}};
	assign ev1 = {|t.chg_stat, |t.ico_stat, 1'b0, |t.bus_stat, 1'b0, r.die_thermal_regulation,
		t.bat_pres, t.port_det} & {8{pr_r}};
	assign fr = {r.sys_short, r.sys_ov, r.rb_ov, r.rb_uv, 1'b0, r.tshut,
		2'b00} & {8{pr_r}};
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pr_r <= 1'b0;
			cq_r <= '0;
			m0_r <= 8'h00;
			m1_r <= 8'h00;
			fl_r <= 8'h00;
		end
		else if (clk_en)
		begin
			pr_r <= 1'b1;
			cq_r <= cond;
			fl_r <= (rd27 ? 8'h00 : fl_r) | fr;
			if (reg_reset_cmd)
			begin
				m0_r <= 8'h00;
				m1_r <= 8'h00;
			end
			else if (req.wr && req.addr == ffm_pkg::MASK_FIRST_OFS)
				m0_r <= req.wdata;
			else if (req.wr && req.addr == ffm_pkg::MASK_SECOND_OFS)
				m1_r <= req.wdata & ffm_pkg::MASK_SECOND_WMASK;
		end
	end
	a_pulse_width: assert property (
		$fell(int_n) |=> (!int_n) [*4] ##1 int_n)
		else $error("interrupt pulse width wrong");
	a_pulse_gap: assert property (
		$rose(int_n) |-> $past(int_n, 6))
		else $error("interrupt low time too long");
	a_int_unmasked: assert property (
		clk_en && int_n && $past(int_n) && |(ev0 & ~m0_r | ev1 & ~m1_r)
		|=> !int_n)
		else $error("unmasked event gave no pulse");
	a_int_masked: assert property (
		int_n && $past(int_n) && !(|(ev0 & ~m0_r | ev1 & ~m1_r)) |=> int_n)
		else $error("pulse without unmasked event");
	a_flag_read: assert property (
		rd27 |=> rdata == $past(fl_r))
		else $error("fault flag readback wrong");
	a_mask0_read: assert property (
		req.rd && req.addr == ffm_pkg::MASK_FIRST_OFS |=> rdata == $past(m0_r))
		else $error("first mask readback wrong");
	a_mask1_read: assert property (
		req.rd && req.addr == ffm_pkg::MASK_SECOND_OFS |=> rdata == $past(m1_r))
		else $error("second mask readback wrong");
	a_reset_clears: assert property (
		reg_reset_cmd ##1 (req.rd && req.addr == ffm_pkg::MASK_FIRST_OFS)
		|=> rdata == 8'h00)
		else $error("register reset left a mask set");
endmodule
bind ffm_regs ffm_regs_properties u_ffm_regs_properties (.clk(clk),
	.reset_n(reset_n), .clk_en(clk_en), .req(req),
	.reg_reset_cmd(reg_reset_cmd), .rdata(rdata), .cond(cond), .int_n(int_n));
`default_nettype wire

// *** verif/ffm_regs_tb.sv ***
// testbench for the flag and mask register block
// assumes the host model counts pulses; clk_en dropped once to freeze state
`timescale 1ns/1ns
`default_nettype none
module ffm_regs_tb;
	logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_reset_cmd = 1'b0;
	ffm_pkg::ffm_req_t req = '0;
	ffm_pkg::ffm_cond_t cond = '0;
	logic [7:0] rdata, pc, p0, v;
	logic int_n;
	int failures = 0, n_tests = 0, seed = 26135, i, k;
	// cond bit positions and their mask bits; first ten in the first mask
	int pos[16] = '{21, 20, 19, 18, 17, 16, 15, 14, 13, 12, 9, 7, 3, 2, 1, 0};
	int mb[16] = '{7, 7, 6, 6, 5, 4, 3, 2, 1, 0, 7, 6, 4, 2, 1, 0};
	always #25 clk = ~clk;
	ffm_regs u_ffm_regs (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.req(req), .reg_reset_cmd(reg_reset_cmd), .rdata(rdata), .cond(cond),
		.int_n(int_n));
	ffm_host_model u_ffm_host_model (.clk(clk), .reset_n(reset_n),
		.int_n(int_n), .pulses(pc));
	function automatic logic [7:0] wm(input logic [7:0] a);
		case (a)
			ffm_pkg::MASK_FIRST_OFS: return ffm_pkg::MASK_FIRST_WMASK;
			ffm_pkg::MASK_SECOND_OFS: return ffm_pkg::MASK_SECOND_WMASK;
			ffm_pkg::MASK_THIRD_OFS: return ffm_pkg::MASK_THIRD_WMASK;
			default: return 8'h00;
		endcase
	endfunction
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask
	task give_verdict;
		$display("failures %0d tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		for (i = 0; i < 5; i++)
		begin
			acc(1'b0, 8'(8'h27 + i), 8'h00);
			chk(rdata, 8'h00);
		end
		for (i = 0; i < 12; i++)
		begin
			v = 8'($random(seed));
			acc(1'b1, 8'(8'h27 + i % 4), v);
			acc(1'b0, 8'(8'h27 + i % 4), 8'h00);
			chk(rdata, v & wm(8'(8'h27 + i % 4)));
		end
		// masks all set first so the register reset has work to do
		for (i = 0; i < 3; i++)
			acc(1'b1, 8'(8'h28 + i), 8'hFF);
		@(negedge clk);
		reg_reset_cmd = 1'b1;
		@(negedge clk);
		reg_reset_cmd = 1'b0;
		req = '{wr: 1'b0, rd: 1'b1, addr: 8'h28, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		chk(rdata, 8'h00);
		for (i = 1; i < 3; i++)
		begin
			acc(1'b0, 8'(8'h28 + i), 8'h00);
			chk(rdata, 8'h00);
		end
		// each event unmasked then masked; rising kinds pulse once only
		for (i = 0; i < 16; i++)
			for (k = 0; k < 2; k++)
			begin
				acc(1'b1, 8'h28, (i < 10 && k) ? 8'(1 << mb[i]) : 8'h00);
				acc(1'b1, 8'h29, (i >= 10 && k) ? 8'(1 << mb[i]) : 8'h00);
				p0 = pc;
				@(negedge clk) cond[pos[i]] = ~cond[pos[i]];
				repeat (8) @(negedge clk);
				cond[pos[i]] = ~cond[pos[i]];
				repeat (8) @(negedge clk);
				chk(pc - p0, k ? 8'h00 : ((i < 6 || i == 13) ? 8'h01 : 8'h02));
			end
		// frozen: a write and a toggle there and back leave no trace
		p0 = pc;
		clk_en = 1'b0;
		cond.pgood = ~cond.pgood;
		acc(1'b1, 8'h28, 8'hFF);
		cond.pgood = ~cond.pgood;
		clk_en = 1'b1;
		acc(1'b0, 8'h28, 8'h00);
		chk(rdata, 8'h00);
		repeat (8) @(negedge clk);
		chk(pc - p0, 8'h00);
		// toggles one cycle apart merge, six apart give two pulses
		for (k = 1; k < 7; k += 5)
		begin
			p0 = pc;
			cond.pgood = ~cond.pgood;
			repeat (k) @(negedge clk);
			cond.pgood = ~cond.pgood;
			repeat (10) @(negedge clk);
			chk(pc - p0, k == 1 ? 8'h01 : 8'h02);
		end
		p0 = pc;
		for (i = 0; i < 6; i++)
		begin
			v = 8'($random(seed));
			cond[26:22] = v[4:0];
			repeat (3) @(negedge clk);
			acc(1'b0, 8'h27, 8'h00);
			chk(rdata, {v[4:1], 1'b0, v[0], 2'b00});
			acc(1'b0, 8'h27, 8'h00);
			chk(rdata, 8'h00);
			cond[26:22] = 5'h00;
			// the low level must be sampled or the next rise is lost
			@(negedge clk);
		end
		chk(pc - p0, 8'h00);
		give_verdict;
	end
	initial
	begin
		repeat (4000) @(negedge clk);
		failures++;
		give_verdict;
	end
endmodule
`default_nettype wire
